// file: hw/fpec_pkg.sv
// Shared constants and types of the flash program and erase controller
package fpec_pkg;

    // Register indices as printed; byte address on APB is four times the index
    localparam logic [15:0] IDX_OVERLAY   = 16'hFEDB;
    localparam logic [15:0] IDX_CTRL_A    = 16'hFFA8;
    localparam logic [15:0] IDX_CTRL_B    = 16'hFFA9;
    localparam logic [15:0] IDX_BLK_LOW   = 16'hFFAA;
    localparam logic [15:0] IDX_BLK_HIGH  = 16'hFFAB;
    localparam int          APB_ADDR_W    = 18;

    // flash_control_a fields
    localparam int BIT_PROGRAM     = 0;
    localparam int BIT_ERASE_START = 1;
    localparam int BIT_PROG_CHECK  = 2;
    localparam int BIT_ERASE_CHECK = 3;
    localparam int BIT_SW_GATE     = 6;
    localparam logic [7:0] CTRL_A_WMASK = 8'h4F;

    // flash_control_b fields
    localparam int BIT_FAULT_FLAG  = 7;

    // overlay_window_reg fields
    localparam int BIT_OVERLAY_ON  = 3;
    localparam int OVL_AREA_MSB    = 2;
    localparam logic [7:0] OVERLAY_WMASK = 8'h0F;

    // Reset values
    localparam logic [7:0] RST_CTRL_A   = 8'h00;
    localparam logic [7:0] RST_BLK_LOW  = 8'h00;
    localparam logic [7:0] RST_BLK_HIGH = 8'h00;
    localparam logic [7:0] RST_OVERLAY  = 8'h00;

    // Page latch and verify arming
    localparam int          PAGE_BYTES  = 128;
    localparam int          PAGE_IDX_W  = 7;
    localparam int          FLASH_ADDR_W = 24;
    localparam logic [7:0]  DUMMY_BYTE  = 8'hFF;
    localparam logic [1:0]  VERIFY_ALIGN = 2'b00;

    typedef enum logic [2:0]
    {
        MODE_IDLE  = 3'b000,
        MODE_PROG  = 3'b001,
        MODE_PVER  = 3'b010,
        MODE_ERASE = 3'b011,
        MODE_EVER  = 3'b100
    } fpec_mode_e;

endpackage

// file: hw/fpec_page_if.sv
// Carrier between the controller and its page buffer
`timescale 1ns/1ps
interface fpec_page_if #(
    parameter int IDX_W  = 7,
    parameter int DATA_W = 8
);
    logic              wrEn;
    logic [IDX_W-1:0]  wrIdx;
    logic [DATA_W-1:0] wrData;
    logic [IDX_W-1:0]  rdIdx;
    logic [DATA_W-1:0] rdData;

    modport ctrl  (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
    modport store (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface

// file: hw/fpec_page_latch.sv
// Page buffer holding the bytes of one program page
`timescale 1ns/1ps
module fpec_page_latch #(
    parameter int DEPTH  = 128,
    parameter int IDX_W  = 7,
    parameter int DATA_W = 8
) (
    input  wire logic  core_clk,
    input  wire logic  rst_b,
    fpec_page_if.store pg
);
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [DATA_W-1:0] rdData_q;

    // Storage is not reset; software always refills a whole page
    always_ff @(posedge core_clk)
    begin
        if (pg.wrEn)
        begin
            mem_q[pg.wrIdx] <= pg.wrData;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            rdData_q <= '0;
        end
        else
        begin
            rdData_q <= mem_q[pg.rdIdx];
        end
    end

    assign pg.rdData = rdData_q;
endmodule

// file: hw/fpec_top.sv
// Flash program and erase controller with APB registers and protection
//
// Overview of operation
// - Control register A picks one of program, program-verify, erase, erase-verify.
// - 128 bytes written in order are latched; page starts at low byte 00 or 80.
// - Programming is applied only while the program bit stays set.
// - Verify is armed by dummy FF write to word-aligned address, then read back.
// - Erase acts on one selected block only; blocks are erased one by one.
// - Erasure is applied only while the erase bit stays set.
// - Warm reset or standby aborts operations and clears control register A and low select.
// - With write gate clear, program and erase bits start nothing.
// - Each low select bit enables one block; zero protects all blocks.
// - Flash read, exception or sleep during program or erase sets the fault flag.
// - On fault, registers stay, operation aborts, and restart is refused.
// - Verify modes may still be entered while the fault flag is set.
// - Fault state clears only on power-on reset.
// - With overlay on, all blocks are protected from program and erase.
`timescale 1ns/1ps
module fpec_top #(
    parameter int PAGE_DEPTH = fpec_pkg::PAGE_BYTES
) (
    input  wire logic                                core_clk,
    input  wire logic                                rst_b,
    input  wire logic                                warmReset,
    input  wire logic                                standbyReq,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [fpec_pkg::APB_ADDR_W-1:0]     paddr,
    input  wire logic [31:0]                         pwdata,
    input  wire logic [3:0]                          pstrb,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic                                flashWrValid,
    input  wire logic [fpec_pkg::FLASH_ADDR_W-1:0]   flashWrAddr,
    input  wire logic [7:0]                          flashWrData,
    input  wire logic                                flashRdAccess,
    input  wire logic                                exceptionTaken,
    input  wire logic                                sleepExec,
    input  wire logic [fpec_pkg::PAGE_IDX_W-1:0]     pageRdIdx,
    output logic      [7:0]                          pageRdData,
    output logic      [fpec_pkg::FLASH_ADDR_W-8:0]   pageBase,
    output logic                                     pageFull,
    output logic                                     progActive,
    output logic                                     eraseActive,
    output logic                                     progVerifyActive,
    output logic                                     eraseVerifyActive,
    output logic      [15:0]                         eraseBlockSel,
    output logic                                     verifyArmed,
    output logic      [fpec_pkg::FLASH_ADDR_W-1:0]   verifyAddr,
    output logic                                     flashStandby,
    output logic                                     overlayActive,
    output logic      [2:0]                          overlayArea
);
    localparam int AW = fpec_pkg::APB_ADDR_W;
    localparam int FW = fpec_pkg::FLASH_ADDR_W;
    localparam int IW = fpec_pkg::PAGE_IDX_W;

    localparam logic [AW-1:0] ADDR_OVERLAY  = {fpec_pkg::IDX_OVERLAY, 2'b00};
    localparam logic [AW-1:0] ADDR_CTRL_A   = {fpec_pkg::IDX_CTRL_A, 2'b00};
    localparam logic [AW-1:0] ADDR_CTRL_B   = {fpec_pkg::IDX_CTRL_B, 2'b00};
    localparam logic [AW-1:0] ADDR_BLK_LOW  = {fpec_pkg::IDX_BLK_LOW, 2'b00};
    localparam logic [AW-1:0] ADDR_BLK_HIGH = {fpec_pkg::IDX_BLK_HIGH, 2'b00};
    localparam logic [IW:0]   PAGE_COUNT_FULL = (IW+1)'(PAGE_DEPTH);

    logic [7:0]            ctrlA_q;
    logic                  fault_q;
    logic [7:0]            blkLow_q;
    logic [7:0]            blkHigh_q;
    logic [7:0]            overlay_q;
    fpec_pkg::fpec_mode_e  mode_q;
    fpec_pkg::fpec_mode_e  mode_d;
    logic [31:0]           prdata_q;
    logic [FW-8:0]         pageBase_q;
    logic [IW:0]           pageCount_q;
    logic                  pageOpen_q;
    logic                  verifyArmed_q;
    logic [FW-1:0]         verifyAddr_q;

    logic                  hwProt;
    logic                  busSetup;
    logic                  busAccess;
    logic                  addrHit;
    logic                  wrStrobe;
    logic                  wrLow;
    logic [7:0]            wrByte;
    logic [7:0]            rdByte;
    logic [3:0]            opBits;
    logic                  opSingle;
    logic                  swGate;
    logic                  eraseBlockOk;
    logic                  arrayBusy;
    logic                  errEvent;
    logic                  pageStart;
    logic                  pageNext;

    fpec_page_if #(.IDX_W(IW), .DATA_W(8)) pg ();

    fpec_page_latch #(
        .DEPTH  (PAGE_DEPTH),
        .IDX_W  (IW),
        .DATA_W (8)
    ) u_page (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pg       (pg.store)
    );

    // Hardware protection: warm reset or standby entry
    assign hwProt = warmReset | standbyReq;

    // APB slave, zero wait states; read data is captured in the setup cycle
    assign busSetup  = psel & ~penable;
    assign busAccess = psel & penable;
    assign addrHit   = (paddr == ADDR_OVERLAY) | (paddr == ADDR_CTRL_A) |
                       (paddr == ADDR_CTRL_B) | (paddr == ADDR_BLK_LOW) |
                       (paddr == ADDR_BLK_HIGH);
    assign pready    = busAccess;
    assign pslverr   = busAccess & ~addrHit;
    assign wrStrobe  = busAccess & pwrite & addrHit;
    assign wrLow     = wrStrobe & pstrb[0];
    assign wrByte    = pwdata[7:0];
    assign prdata    = prdata_q;

    always_comb
    begin
        rdByte = 8'h00;
        unique case (paddr)
            ADDR_OVERLAY:  rdByte = overlay_q;
            ADDR_CTRL_A:   rdByte = ctrlA_q;
            ADDR_CTRL_B:   rdByte = {fault_q, 7'h00};
            ADDR_BLK_LOW:  rdByte = blkLow_q;
            ADDR_BLK_HIGH: rdByte = blkHigh_q;
            default:       rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            prdata_q <= '0;
        end
        else if (busSetup && !pwrite)
        begin
            prdata_q <= {24'h000000, rdByte};
        end
    end

    // Control register A; fault leaves it untouched
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || hwProt)
        begin
            ctrlA_q <= fpec_pkg::RST_CTRL_A;
        end
        else if (wrLow && paddr == ADDR_CTRL_A)
        begin
            ctrlA_q <= wrByte & fpec_pkg::CTRL_A_WMASK;
        end
    end

    // Low block select is cleared by protection, high block select only by reset
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || hwProt)
        begin
            blkLow_q <= fpec_pkg::RST_BLK_LOW;
        end
        else if (wrLow && paddr == ADDR_BLK_LOW)
        begin
            blkLow_q <= wrByte;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            blkHigh_q <= fpec_pkg::RST_BLK_HIGH;
        end
        else if (wrLow && paddr == ADDR_BLK_HIGH)
        begin
            blkHigh_q <= wrByte;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            overlay_q <= fpec_pkg::RST_OVERLAY;
        end
        else if (wrLow && paddr == ADDR_OVERLAY)
        begin
            overlay_q <= wrByte & fpec_pkg::OVERLAY_WMASK;
        end
    end

    // Mode selection
    assign opBits = {ctrlA_q[fpec_pkg::BIT_ERASE_CHECK], ctrlA_q[fpec_pkg::BIT_PROG_CHECK],
                     ctrlA_q[fpec_pkg::BIT_ERASE_START], ctrlA_q[fpec_pkg::BIT_PROGRAM]};
    assign opSingle = $onehot(opBits);
    // Program and erase need the gate, no overlay and no fault
    assign swGate = ctrlA_q[fpec_pkg::BIT_SW_GATE]
                  & ~overlay_q[fpec_pkg::BIT_OVERLAY_ON]
                  & ~fault_q;
    // Exactly one block in both selects, and low select zero protects everything
    assign eraseBlockOk = (blkLow_q != 8'h00)
                        & $onehot({blkHigh_q, blkLow_q});
    assign arrayBusy = (mode_q == fpec_pkg::MODE_PROG) | (mode_q == fpec_pkg::MODE_ERASE);
    assign errEvent  = arrayBusy & (flashRdAccess | exceptionTaken | sleepExec);

    always_comb
    begin
        mode_d = fpec_pkg::MODE_IDLE;
        if (!hwProt && !errEvent && opSingle)
        begin
            if (opBits[0] && swGate)
            begin
                mode_d = fpec_pkg::MODE_PROG;
            end
            else if (opBits[1] && swGate && eraseBlockOk)
            begin
                mode_d = fpec_pkg::MODE_ERASE;
            end
            else if (opBits[2] && ctrlA_q[fpec_pkg::BIT_SW_GATE])
            begin
                mode_d = fpec_pkg::MODE_PVER;
            end
            else if (opBits[3] && ctrlA_q[fpec_pkg::BIT_SW_GATE])
            begin
                mode_d = fpec_pkg::MODE_EVER;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            mode_q <= fpec_pkg::MODE_IDLE;
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    // Fault flag: only a power-on reset clears it, warm reset and standby do not
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            fault_q <= 1'b0;
        end
        else if (errEvent)
        begin
            fault_q <= 1'b1;
        end
    end

    // Page latch: start at a page boundary, then strictly consecutive bytes
    assign pageStart = flashWrValid & (mode_q == fpec_pkg::MODE_IDLE) &
                       ctrlA_q[fpec_pkg::BIT_SW_GATE] & (flashWrAddr[IW-1:0] == '0);
    assign pageNext  = flashWrValid & (mode_q == fpec_pkg::MODE_IDLE) &
                       ctrlA_q[fpec_pkg::BIT_SW_GATE] & pageOpen_q & ~pageStart &
                       (pageCount_q != PAGE_COUNT_FULL) &
                       (flashWrAddr[FW-1:IW] == pageBase_q) &
                       (flashWrAddr[IW-1:0] == pageCount_q[IW-1:0]);

    always_ff @(posedge core_clk)
    begin
        if (!rst_b || hwProt)
        begin
            pageOpen_q  <= 1'b0;
            pageCount_q <= '0;
            pageBase_q  <= '0;
        end
        else if (pageStart)
        begin
            pageOpen_q  <= 1'b1;
            pageCount_q <= (IW+1)'(1);
            pageBase_q  <= flashWrAddr[FW-1:IW];
        end
        else if (pageNext)
        begin
            pageCount_q <= pageCount_q + (IW+1)'(1);
        end
    end

    assign pg.wrEn   = pageStart | pageNext;
    assign pg.wrIdx  = flashWrAddr[IW-1:0];
    assign pg.wrData = flashWrData;
    assign pg.rdIdx  = pageRdIdx;

    // Verify arming: dummy byte to a word-aligned address in a verify mode
    always_ff @(posedge core_clk)
    begin
        if (!rst_b || (mode_q != fpec_pkg::MODE_PVER && mode_q != fpec_pkg::MODE_EVER))
        begin
            verifyArmed_q <= 1'b0;
            verifyAddr_q  <= '0;
        end
        else if (flashWrValid && flashWrData == fpec_pkg::DUMMY_BYTE &&
                 flashWrAddr[1:0] == fpec_pkg::VERIFY_ALIGN)
        begin
            verifyArmed_q <= 1'b1;
            verifyAddr_q  <= flashWrAddr;
        end
    end

    // Outputs; eraseBlockSel is the select register content, valid during erase only
    assign pageRdData        = pg.rdData;
    assign pageBase          = pageBase_q;
    assign pageFull          = pageCount_q == PAGE_COUNT_FULL;
    assign progActive        = mode_q == fpec_pkg::MODE_PROG;
    assign eraseActive       = mode_q == fpec_pkg::MODE_ERASE;
    assign progVerifyActive  = mode_q == fpec_pkg::MODE_PVER;
    assign eraseVerifyActive = mode_q == fpec_pkg::MODE_EVER;
    assign eraseBlockSel     = eraseActive ? {blkHigh_q, blkLow_q} : 16'h0000;
    assign verifyArmed       = verifyArmed_q;
    assign verifyAddr        = verifyAddr_q;
    assign flashStandby      = standbyReq;
    assign overlayActive     = overlay_q[fpec_pkg::BIT_OVERLAY_ON];
    assign overlayArea       = overlay_q[fpec_pkg::OVL_AREA_MSB:0];
endmodule

// file: tb/fpec_top_properties.sv
// Concurrent checks on the ports of the flash program and erase controller
`timescale 1ns/1ps
module fpec_checker (
    input wire logic                              core_clk,
    input wire logic                              rst_b,
    input wire logic                              warmReset,
    input wire logic                              standbyReq,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic                              pwrite,
    input wire logic [fpec_pkg::APB_ADDR_W-1:0]   paddr,
    input wire logic [31:0]                       pwdata,
    input wire logic [3:0]                        pstrb,
    input wire logic                              pready,
    input wire logic                              flashWrValid,
    input wire logic [fpec_pkg::FLASH_ADDR_W-1:0] flashWrAddr,
    input wire logic [7:0]                        flashWrData,
    input wire logic                              flashRdAccess,
    input wire logic                              exceptionTaken,
    input wire logic                              sleepExec,
    input wire logic                              progActive,
    input wire logic                              eraseActive,
    input wire logic                              progVerifyActive,
    input wire logic                              eraseVerifyActive,
    input wire logic [15:0]                       eraseBlockSel,
    input wire logic                              verifyArmed,
    input wire logic [fpec_pkg::FLASH_ADDR_W-1:0] verifyAddr,
    input wire logic                              flashStandby,
    input wire logic                              overlayActive
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [3:0] ops;
    logic       caWr;
    logic       inVer;
    assign ops = {progActive, eraseActive, progVerifyActive, eraseVerifyActive};
    assign caWr = psel && penable && pwrite && pstrb[0] && paddr == {fpec_pkg::IDX_CTRL_A, 2'b00};
    assign inVer = progVerifyActive || eraseVerifyActive;
    sequence s_fault_ev;
        (progActive || eraseActive) && (flashRdAccess || exceptionTaken || sleepExec);
    endsequence
    sequence s_dummy;
        inVer && flashWrValid && flashWrData == 8'hFF && flashWrAddr[1:0] == 2'h0
            && !warmReset && !standbyReq;
    endsequence
    property p_one_op; $onehot0(ops); endproperty
    property p_hw_abort; warmReset || standbyReq |=> ops == 4'h0; endproperty
    property p_standby; standbyReq |-> flashStandby; endproperty
    property p_fault_abort; s_fault_ev |=> !progActive && !eraseActive; endproperty
    // Two edges: control register lands first, mode register one edge later
    property p_prog_hold; caWr && !(pwdata[0] && pwdata[6]) |-> ##2 !progActive; endproperty
    property p_erase_hold; caWr && !(pwdata[1] && pwdata[6]) |-> ##2 !eraseActive; endproperty
    property p_erase_sel;
        eraseActive |-> $onehot(eraseBlockSel) && eraseBlockSel[7:0] != 8'h00;
    endproperty
    property p_overlay; progActive || eraseActive |-> !$past(overlayActive); endproperty
    property p_arm; s_dummy ##1 inVer |-> verifyArmed && verifyAddr == $past(flashWrAddr); endproperty
    property p_ready; psel && penable |-> pready; endproperty
    a_one_op: assert property (p_one_op)
        else $error("more than one array operation active");
    a_hw_abort: assert property (p_hw_abort)
        else $error("reset or standby did not stop the array");
    a_standby: assert property (p_standby)
        else $error("standby not passed to the flash");
    a_fault_abort: assert property (p_fault_abort)
        else $error("fault event did not abort program or erase");
    a_prog_hold: assert property (p_prog_hold)
        else $error("programming outlived its enable");
    a_erase_hold: assert property (p_erase_hold)
        else $error("erasure outlived its enable");
    a_erase_sel: assert property (p_erase_sel)
        else $error("erase without a single low block selected");
    a_overlay: assert property (p_overlay)
        else $error("array operation started under overlay");
    a_arm: assert property (p_arm)
        else $error("dummy write did not arm verify");
    a_ready: assert property (p_ready)
        else $error("access phase without ready");
endmodule
bind fpec_top fpec_checker u_fpec_checker (.core_clk(core_clk), .rst_b(rst_b),
    .warmReset(warmReset), .standbyReq(standbyReq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .flashWrValid(flashWrValid), .flashWrAddr(flashWrAddr), .flashWrData(flashWrData),
    .flashRdAccess(flashRdAccess), .exceptionTaken(exceptionTaken), .sleepExec(sleepExec),
    .progActive(progActive), .eraseActive(eraseActive), .progVerifyActive(progVerifyActive),
    .eraseVerifyActive(eraseVerifyActive), .eraseBlockSel(eraseBlockSel),
    .verifyArmed(verifyArmed), .verifyAddr(verifyAddr), .flashStandby(flashStandby),
    .overlayActive(overlayActive));

// file: tb/tb.sv
// Register-level testbench of the flash program and erase controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
    localparam logic [17:0] A_OVL = {fpec_pkg::IDX_OVERLAY, 2'b00};
    localparam logic [17:0] A_CA  = {fpec_pkg::IDX_CTRL_A, 2'b00};
    localparam logic [17:0] A_CB  = {fpec_pkg::IDX_CTRL_B, 2'b00};
    localparam logic [17:0] A_BL  = {fpec_pkg::IDX_BLK_LOW, 2'b00};
    localparam logic [17:0] A_BH  = {fpec_pkg::IDX_BLK_HIGH, 2'b00};
    logic        core_clk, rst_b, warmReset, standbyReq, psel, penable, pwrite;
    logic        flashWrValid, flashRdAccess, exceptionTaken, sleepExec, se;
    logic        pready, pslverr, pageFull, progActive, eraseActive, progVerifyActive;
    logic        eraseVerifyActive, verifyArmed, flashStandby, overlayActive;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [23:0] flashWrAddr, verifyAddr;
    logic [7:0]  flashWrData, pageRdData;
    logic [6:0]  pageRdIdx;
    logic [16:0] pageBase;
    logic [15:0] eraseBlockSel;
    logic [2:0]  overlayArea;
    int          err_total, total_checks;

    fpec_top u_fpec_top (.core_clk(core_clk), .rst_b(rst_b), .warmReset(warmReset),
        .standbyReq(standbyReq), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flashWrValid(flashWrValid), .flashWrAddr(flashWrAddr),
        .flashWrData(flashWrData), .flashRdAccess(flashRdAccess),
        .exceptionTaken(exceptionTaken), .sleepExec(sleepExec), .pageRdIdx(pageRdIdx),
        .pageRdData(pageRdData), .pageBase(pageBase), .pageFull(pageFull),
        .progActive(progActive), .eraseActive(eraseActive),
        .progVerifyActive(progVerifyActive), .eraseVerifyActive(eraseVerifyActive),
        .eraseBlockSel(eraseBlockSel), .verifyArmed(verifyArmed), .verifyAddr(verifyAddr),
        .flashStandby(flashStandby), .overlayActive(overlayActive), .overlayArea(overlayArea));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // One APB transfer, then an idle cycle so the next call never re-drives psel in one step
    task automatic apb(input logic [17:0] a, input logic w, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // No wait limit here: only the watchdog ends a stalled transfer
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdc(input logic [17:0] a, input logic [7:0] e);
        apb(a, 1'b0, 8'h00);
        `CHK($sformatf("reg %0h", a), {24'h0, e}, rd)
    endtask

    task automatic act(input logic [3:0] e);
        wt(3);
        `CHK("mode", e, {progActive, eraseActive, progVerifyActive, eraseVerifyActive})
    endtask

    task automatic fw(input logic [23:0] a, input logic [7:0] d);
        flashWrValid <= 1'b1;
        flashWrAddr <= a;
        flashWrData <= d;
        @(posedge core_clk);
        flashWrValid <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic do_reset;
        @(posedge core_clk);
        rst_b <= 1'b0;
        wt(12);
        rst_b <= 1'b1;
        wt(1);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        wt(20000);
        err_total++;
        end_sim();
    end

    initial
    begin
        logic [17:0] regs [5];
        logic [7:0]  md [4];
        logic [3:0]  ex [4];
        regs = '{A_OVL, A_CA, A_CB, A_BL, A_BH};
        md = '{8'h41, 8'h42, 8'h44, 8'h48};
        ex = '{4'b1000, 4'b0100, 4'b0010, 4'b0001};
        {rst_b, warmReset, standbyReq, psel, penable, pwrite, flashWrValid} = 7'h00;
        {flashRdAccess, exceptionTaken, sleepExec, paddr, pwdata} = '0;
        {flashWrAddr, flashWrData, pageRdIdx} = '0;
        pstrb = 4'hF;
        do_reset();
        for (int i = 0; i < 5; i++) rdc(regs[i], 8'h00);
        apb(18'h00100, 1'b0, 8'h00);
        `CHK("slverr", 1'b1, se)
        apb(A_CB, 1'b1, 8'hFF);
        rdc(A_CB, 8'h00);
        apb(A_CA, 1'b1, 8'h01);
        act(4'b0000);
        apb(A_BH, 1'b1, 8'h01);
        apb(A_CA, 1'b1, 8'h42);
        act(4'b0000);
        apb(A_BH, 1'b1, 8'h00);
        apb(A_BL, 1'b1, 8'h03);
        act(4'b0000);
        apb(A_BL, 1'b1, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            apb(A_CA, 1'b1, 8'h40);
            apb(A_CA, 1'b1, md[i]);
            act(ex[i]);
            if (i == 1) `CHK("blocks", 16'h0001, eraseBlockSel)
            rdc(A_CA, md[i]);
            apb(A_CA, 1'b1, 8'h40);
            act(4'b0000);
        end
        apb(A_OVL, 1'b1, 8'h0B);
        `CHK("overlay", 4'hB, {overlayActive, overlayArea})
        apb(A_CA, 1'b1, 8'h41);
        act(4'b0000);
        apb(A_OVL, 1'b1, 8'h00);
        act(4'b1000);
        apb(A_CA, 1'b1, 8'h40);
        for (int i = 0; i < 128; i++)
        begin
            fw(24'h000180 + 24'(i), 8'(i) ^ 8'h5A);
            if (i == 126) `CHK("full", 1'b0, pageFull)
        end
        `CHK("full", 1'b1, pageFull)
        `CHK("base", 17'h00003, pageBase)
        pageRdIdx <= 7'h7F;
        wt(2);
        `CHK("page", 8'h25, pageRdData)
        apb(A_CA, 1'b1, 8'h44);
        wt(3);
        fw(24'h000108, 8'h7E);
        fw(24'h000105, 8'hFF);
        `CHK("armed", 1'b0, verifyArmed)
        fw(24'h000104, 8'hFF);
        `CHK("armed", 25'h1000104, {verifyArmed, verifyAddr})
        for (int k = 0; k < 2; k++)
        begin
            apb(A_BL, 1'b1, 8'h01);
            apb(A_CA, 1'b1, 8'h41);
            act(4'b1000);
            {standbyReq, warmReset} <= k ? 2'b10 : 2'b01;
            @(posedge core_clk);
            `CHK("standby", k == 1, flashStandby)
            {standbyReq, warmReset} <= 2'b00;
            act(4'b0000);
            rdc(A_CA, 8'h00);
            rdc(A_BL, 8'h00);
        end
        for (int k = 0; k < 3; k++)
        begin
            do_reset();
            apb(A_CA, 1'b1, 8'h41);
            act(4'b1000);
            {sleepExec, exceptionTaken, flashRdAccess} <= 3'b001 << k;
            @(posedge core_clk);
            {sleepExec, exceptionTaken, flashRdAccess} <= 3'b000;
            act(4'b0000);
            rdc(A_CB, 8'h80);
            rdc(A_CA, 8'h41);
            apb(A_CA, 1'b1, 8'h40);
            apb(A_CA, 1'b1, 8'h41);
            act(4'b0000);
            apb(A_CA, 1'b1, 8'h44);
            act(4'b0010);
            warmReset <= 1'b1;
            @(posedge core_clk);
            warmReset <= 1'b0;
            rdc(A_CB, 8'h80);
        end
        do_reset();
        rdc(A_CB, 8'h00);
        end_sim();
    end
endmodule
